// ==== design/sdadc_pkg.sv ====
// constants, modes and states for the converter serial output port
// Functional notes
// - cs released mid-word: finish current bit, then float data and clock lines.
// - cs is ignored during the four-cycle word update interval.
// - external-clock mode: next data bit follows each falling host clock edge.
// - self-clock mode: data changes after each falling edge of generated clock.
// - self-clock mode drives shift clock at master clock over four, 25% high.
// - valid flag low while data waits; high after send and four cycles on load.
// - calibration pin high over four cycles resets; calibration starts on release.
// - cs assertion starts a transfer in the format picked by the mode pins.
package sdadc_pkg;
  localparam int          WORD_BITS      = 16;
  localparam logic [4:0]  WORD_BITS_CNT  = 5'h10;
  localparam int          CLK_PERIOD_NS  = 4;
  localparam logic [2:0]  UPDATE_CNT     = 3'h4;
  localparam logic [2:0]  CAL_HOLD_CNT   = 3'h4;
  localparam logic [1:0]  SELF_HIGH_PH   = 2'h3;
  localparam logic [1:0]  SELF_PRE_HIGH  = 2'h2;
  localparam logic [7:0]  UART_BIT_LAST  = 8'h0F;
  localparam int          HOST_GAP_NS    = 160;
  localparam int          HOST_GAP_CYC   = (HOST_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // idle pin levels: cs_n and sleep_n high, cal and shift clock low, mode zero
  localparam logic [5:0]  SYNC_RST       = 6'h0A;
  localparam logic [15:0] WORD_RST       = 16'h0000;
  localparam logic        VALID_N_RST    = 1'b1;

  typedef logic [1:0] mode_t;
  localparam mode_t MODE_SELF = 2'h0;
  localparam mode_t MODE_EXT  = 2'h1;
  localparam mode_t MODE_UART = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } port_state_e;
endpackage

// ==== design/sdadc_serial_port.sv ====
// serial output port and calibration control of the sigma-delta converter
`timescale 1ns/100ps
module sdadc_serial_port (
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  input  wire logic [15:0]       result_i,
  input  wire logic              result_load_i,
  input  wire logic              cs_n_i,
  input  wire sdadc_pkg::mode_t  mode_sel_i,
  input  wire logic              cal_i,
  input  wire logic              sleep_n_i,
  input  wire logic              shift_clk_i,
  output logic                   shift_clk_o,
  output logic                   shift_clk_oe_n_o,
  output logic                   serial_out_line_o,
  output logic                   serial_out_line_oe_n_o,
  output logic                   word_valid_flag_n_o,
  output logic                   cal_reset_o,
  output logic                   cal_start_o
);
  import sdadc_pkg::*;

  shift_if sh ();
  word_shifter u_shift (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .sh     (sh)
  );

  // two-stage synchroniser for every pin level
  logic [5:0]  meta_q;
  logic [5:0]  sync_q;
  logic        cs_n_s;
  logic        sclk_s;
  logic        cal_s;
  logic        sleep_s;
  mode_t       mode_s;
  logic        sclk_prev_q;
  logic        sclk_fall;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= SYNC_RST;
      sync_q <= SYNC_RST;
    end else begin
      meta_q <= {mode_sel_i, sleep_n_i, cal_i, cs_n_i, shift_clk_i};
      sync_q <= meta_q;
    end
  end

  assign sclk_s  = sync_q[0];
  assign cs_n_s  = sync_q[1];
  assign cal_s   = sync_q[2];
  assign sleep_s = sync_q[3];
  assign mode_s  = sync_q[5:4];

  always_ff @(posedge clk_i) begin
    if (srst_i) sclk_prev_q <= 1'b0;
    else        sclk_prev_q <= sclk_s;
  end
  // host is trusted to keep the clock low long enough after cs for this to be first edge
  assign sclk_fall = sclk_prev_q & ~sclk_s;

  // calibration pin: reset after a long high, calibration pulse on release
  logic [2:0] cal_cnt_q;
  logic       cal_reset_q;
  logic       cal_start_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cal_cnt_q   <= 3'h0;
      cal_reset_q <= 1'b0;
      cal_start_q <= 1'b0;
    end else begin
      cal_start_q <= 1'b0;
      if (!cal_s) cal_cnt_q <= 3'h0;
      else if (cal_cnt_q != CAL_HOLD_CNT) cal_cnt_q <= cal_cnt_q + 3'h1;
      if (cal_s && cal_cnt_q == CAL_HOLD_CNT) begin
        cal_reset_q <= 1'b1;
      end else if (cal_reset_q && !cal_s) begin
        cal_reset_q <= 1'b0;
        cal_start_q <= 1'b1;
      end
    end
  end

  // held result and valid flag
  logic [15:0]  held_q;
  logic [2:0]   upd_cnt_q;
  logic         valid_n_q;
  port_state_e  state_q;
  mode_t        mode_q;
  logic [1:0]   phase_q;
  logic [7:0]   baud_q;
  logic         start_bit_q;
  logic         stop_q;
  logic         sclk_q;
  logic         sclk_oe_n_q;
  logic         serial_out_line_q;
  logic         serial_out_line_oe_n_q;
  logic         bit_end;
  logic         finished;
  logic         abort;
  logic         start;
  logic         done;

  always_ff @(posedge clk_i) begin
    if (srst_i) held_q <= WORD_RST;
    else if (result_load_i) held_q <= result_i;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      upd_cnt_q <= 3'h0;
      valid_n_q <= VALID_N_RST;
    end else begin
      if (result_load_i) upd_cnt_q <= UPDATE_CNT;
      else if (upd_cnt_q != 3'h0) upd_cnt_q <= upd_cnt_q - 3'h1;
      // the end of an update beats a transfer finishing in the same cycle, but one finishing later still sets the valid flag high over a fresh word
      if (cal_reset_q) valid_n_q <= 1'b1;
      else if (result_load_i) valid_n_q <= 1'b1;
      else if (upd_cnt_q == 3'h1) valid_n_q <= 1'b0;
      else if (done) valid_n_q <= 1'b1;
    end
  end

  // cs is only seen with a settled valid word
  assign start = (state_q == ST_IDLE) && !cs_n_s && !valid_n_q && (upd_cnt_q == 3'h0)
                 && !result_load_i && sleep_s && !cal_reset_q;
  assign abort = cal_reset_q | ~sleep_s;

  always_comb begin
    bit_end = 1'b0;
    case (mode_q)
      MODE_EXT:  bit_end = sclk_fall;
      MODE_UART: bit_end = (baud_q == UART_BIT_LAST);
      default:   bit_end = (phase_q == SELF_HIGH_PH);
    endcase
    bit_end  = bit_end && (state_q == ST_SHIFT);
    finished = (mode_q == MODE_UART) ? stop_q : sh.last;
  end

  assign done       = bit_end && finished && !abort;
  assign sh.load    = start;
  assign sh.word    = held_q;
  assign sh.advance = bit_end && !cs_n_s && !finished && !abort
                      && !((mode_q == MODE_UART) && start_bit_q);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q      <= ST_IDLE;
      mode_q       <= MODE_SELF;
      phase_q      <= 2'h0;
      baud_q       <= 8'h00;
      start_bit_q  <= 1'b0;
      stop_q       <= 1'b0;
      sclk_q       <= 1'b0;
      sclk_oe_n_q  <= 1'b1;
      serial_out_line_q      <= 1'b0;
      serial_out_line_oe_n_q <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          phase_q <= 2'h0;
          baud_q  <= 8'h00;
          sclk_q  <= 1'b0;
          if (start) begin
            state_q      <= ST_SHIFT;
            mode_q       <= mode_s;
            start_bit_q  <= (mode_s == MODE_UART);
            stop_q       <= 1'b0;
            serial_out_line_q      <= (mode_s == MODE_UART) ? 1'b0 : held_q[15];
            serial_out_line_oe_n_q <= 1'b0;
            sclk_oe_n_q  <= (mode_s == MODE_UART || mode_s == MODE_EXT);
          end
        end
        ST_SHIFT: begin
          phase_q <= phase_q + 2'h1;
          baud_q  <= bit_end ? 8'h00 : baud_q + 8'h01;
          // the spare mode code runs as self clock, so it must toggle the clock too
          sclk_q  <= (mode_q != MODE_EXT) && (mode_q != MODE_UART)
                     && (phase_q == SELF_PRE_HIGH) && !abort;
          if (abort || (bit_end && (cs_n_s || finished))) begin
            state_q      <= ST_IDLE;
            serial_out_line_oe_n_q <= 1'b1;
            sclk_oe_n_q  <= 1'b1;
          end else if (bit_end && (mode_q == MODE_UART) && start_bit_q) begin
            start_bit_q <= 1'b0;
            serial_out_line_q     <= sh.cur_bit;
          end else if (bit_end && (mode_q == MODE_UART) && sh.last) begin
            stop_q  <= 1'b1;
            serial_out_line_q <= 1'b1;
          end else if (sh.advance) begin
            serial_out_line_q <= sh.next_bit;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign shift_clk_o            = sclk_q;
  assign shift_clk_oe_n_o       = sclk_oe_n_q;
  assign serial_out_line_o      = serial_out_line_q;
  assign serial_out_line_oe_n_o = serial_out_line_oe_n_q;
  assign word_valid_flag_n_o    = valid_n_q;
  assign cal_reset_o            = cal_reset_q;
  assign cal_start_o            = cal_start_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_abort_release: assert property (
    (bit_end && cs_n_s) |=> (serial_out_line_oe_n_q && sclk_oe_n_q && state_q == ST_IDLE))
    else $error("lines not released after cs drop");
  a_cs_update_gap: assert property (
    (state_q == ST_IDLE && upd_cnt_q != 3'h0) |=> (state_q == ST_IDLE))
    else $error("transfer started during word update");
  a_ext_fall_bit: assert property (
    (mode_q == MODE_EXT && sh.advance) |=> (serial_out_line_q == $past(sh.next_bit)))
    else $error("external clock bit not presented");
  a_self_data_fall: assert property (
    (state_q == ST_SHIFT && mode_q == MODE_SELF && $past(state_q) == ST_SHIFT
     && $changed(serial_out_line_q)) |-> $fell(sclk_q))
    else $error("self clock data changed off falling edge");
  a_self_clk_duty: assert property (
    $rose(sclk_q) |=> (!sclk_q) [*3])
    else $error("self clock high longer than one quarter");
  a_valid_on_load: assert property (
    result_load_i |=> valid_n_q [*4])
    else $error("valid flag low during update");
  a_valid_after_done: assert property (
    done |=> valid_n_q)
    else $error("valid flag low after full word");
  a_cal_hold_reset: assert property (
    ($rose(cal_s) ##0 cal_s [*5]) |=> cal_reset_q)
    else $error("long calibration pulse gave no reset");
  a_cal_release: assert property (
    ($fell(cal_s) && cal_reset_q) |=> cal_start_q)
    else $error("no calibration after release");
  a_start_format: assert property (
    start |=> (state_q == ST_SHIFT && mode_q == $past(mode_s) && !serial_out_line_oe_n_q))
    else $error("cs did not start transfer in selected format");
  a_msb_first: assert property (
    (start && mode_s != MODE_UART) |=> (serial_out_line_q == $past(held_q[15])))
    else $error("first bit is not the msb");

  c_self_word: cover property (done && mode_q == MODE_SELF);
  c_ext_word:  cover property (done && mode_q == MODE_EXT);
  c_uart_word: cover property (done && mode_q == MODE_UART);
  c_cs_abort:  cover property (bit_end && cs_n_s && !finished);
endmodule // sdadc_serial_port

// ==== design/shift_if.sv ====
// carrier between the port controller and the word shifter
`timescale 1ns/100ps
interface shift_if;
  logic        load;
  logic [15:0] word;
  logic        advance;
  logic        cur_bit;
  logic        next_bit;
  logic        last;
  modport ctrl    (output load, output word, output advance,
                   input cur_bit, input next_bit, input last);
  modport shifter (input load, input word, input advance,
                   output cur_bit, output next_bit, output last);
endinterface

// ==== design/word_shifter.sv ====
// sixteen-bit result shifter, most significant bit leaves first
`timescale 1ns/100ps
module word_shifter (
  input  wire logic clk_i,
  input  wire logic srst_i,
  shift_if.shifter  sh
);
  import sdadc_pkg::*;

  logic [15:0] sr_q;
  logic [4:0]  cnt_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sr_q  <= WORD_RST;
      cnt_q <= 5'h00;
    end else if (sh.load) begin
      sr_q  <= sh.word;
      cnt_q <= WORD_BITS_CNT;
    end else if (sh.advance) begin
      sr_q  <= {sr_q[14:0], 1'b0};
      cnt_q <= cnt_q - 5'h01;
    end
  end

  assign sh.cur_bit  = sr_q[15];
  assign sh.next_bit = sr_q[14];
  assign sh.last     = (cnt_q == 5'h01);
endmodule // word_shifter

// ==== verification/adc_host_model.sv ====
// host side of the serial port: receiver and external shift clock source
`timescale 1ns/100ps
module adc_host_model (
  input  wire logic   clk_i,
  input  wire logic   sclk_i,
  input  wire logic   serial_out_line_i,
  output logic        sclk_o,
  output logic [15:0] word_o
);
  import sdadc_pkg::*;
  initial begin
    sclk_o = 1'b0;
    word_o = 16'h0000;
  end
  // bits are taken on the rising edge, across which the device holds data stable
  always @(posedge sclk_i) begin
    word_o <= {word_o[14:0], serial_out_line_i};
  end
  task automatic clear();
    word_o = 16'h0000;
  endtask
  // clock stands low outside frames; the long lead-in covers an unsynchronised select
  task automatic ext_word();
    repeat (HOST_GAP_CYC + 8) @(posedge clk_i);
    #1;
    repeat (WORD_BITS) begin
      sclk_o = 1'b1;
      #80;
      sclk_o = 1'b0;
      #80;
    end
  endtask
endmodule // adc_host_model

// ==== verification/sigma_delta_adc_serial_port_tb_top.sv ====
// self-checking bench for the converter serial output port
`timescale 1ns/100ps
module sigma_delta_adc_serial_port_tb_top;
  import sdadc_pkg::*;
  logic        clk_i         = 1'b0;
  logic        srst_i        = 1'b1;
  logic [15:0] result_i      = 16'h0000;
  logic        result_load_i = 1'b0;
  logic        cs_n_i        = 1'b1;
  mode_t       mode_sel_i    = MODE_SELF;
  logic        cal_i         = 1'b0;
  logic        sleep_n_i     = 1'b1;
  logic        sd_last       = 1'b0;
  logic        sclk_o, sclk_oe_n, sd_o, sd_oe_n, flag_n, cal_rst, cal_go, sclk_host;
  logic [15:0] rx_word, uart_word;
  int          fails           = 0;
  int          samples_checked = 0;
  int          hi_cnt, oe_cnt;
  // a released data line has no pull: show the inverse of the last driven bit
  wire         sd_w   = sd_oe_n ? ~sd_last : sd_o;
  wire         sclk_w = sclk_oe_n ? sclk_host : sclk_o;
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (!sd_oe_n) sd_last <= sd_o;

  sdadc_serial_port i_dut (.clk_i(clk_i), .srst_i(srst_i), .result_i(result_i),
    .result_load_i(result_load_i), .cs_n_i(cs_n_i), .mode_sel_i(mode_sel_i),
    .cal_i(cal_i), .sleep_n_i(sleep_n_i), .shift_clk_i(sclk_w), .shift_clk_o(sclk_o),
    .shift_clk_oe_n_o(sclk_oe_n), .serial_out_line_o(sd_o),
    .serial_out_line_oe_n_o(sd_oe_n), .word_valid_flag_n_o(flag_n),
    .cal_reset_o(cal_rst), .cal_start_o(cal_go));
  adc_host_model i_host (.clk_i(clk_i), .sclk_i(sclk_w), .serial_out_line_i(sd_w),
    .sclk_o(sclk_host), .word_o(rx_word));

  task automatic tick(int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_oe(logic v, int bound);
    for (int i = 0; i < bound && sd_oe_n !== v; i++) tick();
    if (sd_oe_n !== v) begin
      fails++;
      $display("mismatch at %0t: data enable wait ran out", $time);
      stop_test();
    end
  endtask
  task automatic start(logic [15:0] w, mode_t m);
    i_host.clear();
    mode_sel_i    = m;
    result_i      = w;
    result_load_i = 1'b1;
    tick();
    result_load_i = 1'b0;
    tick(6);
    cs_n_i = 1'b0;
    wait_oe(1'b0, 8);
  endtask

  task automatic t_self();
    mode_sel_i    = MODE_SELF;
    result_i      = 16'hA5C3;
    result_load_i = 1'b1;
    tick();
    result_load_i = 1'b0;
    cs_n_i        = 1'b0;
    // select arrives inside the update interval and must wait for it
    repeat (4) begin
      check(flag_n, 1'b1);
      check(sd_oe_n, 1'b1);
      tick();
    end
    check(flag_n, 1'b0);
    wait_oe(1'b0, 8);
    hi_cnt = 0;
    oe_cnt = 0;
    while (sd_oe_n === 1'b0 && oe_cnt < 80) begin
      hi_cnt += int'(sclk_o);
      oe_cnt++;
      tick();
    end
    check(16'(hi_cnt), 16'h0010);
    check(16'(oe_cnt), 16'h0040);
    check(rx_word, 16'hA5C3);
    check(flag_n, 1'b1);
    cs_n_i = 1'b1;
  endtask
  task automatic t_ext();
    start(16'h3C5A, MODE_EXT);
    i_host.ext_word();
    tick(6);
    check(rx_word, 16'h3C5A);
    check(sd_oe_n, 1'b1);
    check(sclk_oe_n, 1'b1);
    check(flag_n, 1'b1);
    cs_n_i = 1'b1;
  endtask
  task automatic t_abort();
    start(16'hFFFF, MODE_SELF);
    tick(20);
    cs_n_i = 1'b1;
    wait_oe(1'b1, 12);
    check(sclk_oe_n, 1'b1);
    check(flag_n, 1'b0);
  endtask
  task automatic t_sleep();
    // spare mode code runs as self clock; standby drops the lines at once
    start(16'h0F0F, 2'h3);
    tick(7);
    check(sclk_o, 1'b1);
    check(sclk_oe_n, 1'b0);
    sleep_n_i = 1'b0;
    wait_oe(1'b1, 6);
    check(sclk_oe_n, 1'b1);
    check(flag_n, 1'b0);
    cs_n_i = 1'b1;
    tick(4);
    sleep_n_i = 1'b1;
  endtask
  task automatic t_uart();
    start(16'h9A6C, MODE_UART);
    tick(8);
    check(sd_w, 1'b0);
    for (int i = 0; i < 16; i++) begin
      tick(16);
      uart_word = {uart_word[14:0], sd_w};
    end
    tick(16);
    check(sd_w, 1'b1);
    check(uart_word, 16'h9A6C);
    cs_n_i = 1'b1;
    wait_oe(1'b1, 24);
    check(flag_n, 1'b1);
  endtask
  task automatic t_cal();
    cal_i = 1'b1;
    tick(3);
    cal_i = 1'b0;
    tick(4);
    check(cal_rst, 1'b0);
    cal_i = 1'b1;
    tick(9);
    check(cal_rst, 1'b1);
    cal_i = 1'b0;
    for (int i = 0; i < 8 && cal_go !== 1'b1; i++) tick();
    check(cal_go, 1'b1);
  endtask

  initial begin
    tick(3);
    srst_i = 1'b0;
    check(flag_n, 1'b1);
    check(sd_oe_n, 1'b1);
    check(sclk_oe_n, 1'b1);
    tick(2);
    t_self();
    t_ext();
    t_abort();
    t_sleep();
    t_uart();
    t_cal();
    stop_test();
  end
endmodule // sigma_delta_adc_serial_port_tb_top
